//--- core/pcs_defs.svh
// Purpose: constants for the program counter, return stack and indirect addressing
// Assumes: included by bare name
// Notes: definitions only
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
// =====================================================================
// widths and reset values
`define PCS_PC_W 13
`define PCS_LOW_W 8
`define PCS_HIGH_W 5
`define PCS_DEPTH 8
`define PCS_PTR_W 3
`define PCS_PC_RST 13'h0000
`define PCS_LATCH_RST 8'h00
// =====================================================================
// field positions
`define PCS_JMP_HI_MSB 4
`define PCS_JMP_HI_LSB 3
`define PCS_JMP_W 11
`define PCS_IND_ADDR_W 9
// virtual indirect-access register, direct address within a bank
`define PCS_IND_REG_ADDR 7'h00
`define PCS_ZERO_BYTE 8'h00
`endif

//--- core/pcs_flow.sv
// Purpose: program counter, upper-address latch, return stack and indirect addressing
// Assumes: one flow operation per cycle from the execution unit
// Notes: all state on I_SYS_CLK, synchronous active-low reset
`timescale 1ns/1ps
`include "pcs_defs.svh"
// Operation
// R1: 13-bit counter; low byte readable and writable by software.
// R2: upper five counter bits reachable only via the latch.
// R3: every reset clears the entire counter.
// R4: low-byte write loads low byte and copies latch 4:0 into bits 12:8.
// R5: jump or call takes bits 12:11 from latch 4:3.
// R6: software bumps the latch on table rollover past 0xFF.
// R7: eight-deep 13-bit stack, pointer hidden from software.
// R8: call and interrupt push the counter.
// R9: all three return kinds pop into the counter.
// R10: push and pop leave the latch untouched.
// R11: stack is circular; ninth push overwrites first entry.
// R12: no overflow or underflow status exists.
// R13: virtual indirect register has no storage; redirects via pointer.
// R14: indirect read of the virtual register itself returns zero.
// R15: indirect write to the virtual register itself stores nothing.
// R16: 9-bit indirect address from pointer and bank-select bit.
// R17: otherwise counter steps by one, wrapping over 13 bits.
// R18: bank-select bit is the address MSB.
module pcs_flow
(
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	input wire pcs_pkg::pcs_flow_req_t I_FLOW,
	input wire logic I_LATCH_WR,
	input wire logic [`PCS_LOW_W-1:0] I_LATCH_DATA,
	input wire logic [`PCS_LOW_W-1:0] I_FILE_POINTER,
	input wire logic I_INDIRECT_BANK_SELECT,
	input wire pcs_pkg::pcs_ind_req_t I_IND,
	input wire logic [`PCS_LOW_W-1:0] I_MEM_RDATA,
	output logic [`PCS_PC_W-1:0] O_INSTRUCTION_POINTER,
	output logic [`PCS_LOW_W-1:0] O_COUNTER_LOW_BYTE,
	output logic [`PCS_LOW_W-1:0] O_UPPER_ADDRESS_LATCH,
	output logic [`PCS_IND_ADDR_W-1:0] O_MEM_ADDR,
	output logic O_MEM_RD,
	output logic O_MEM_WR,
	output logic [`PCS_LOW_W-1:0] O_MEM_WDATA,
	output logic [`PCS_LOW_W-1:0] O_IND_RDATA
);
	import pcs_pkg::*;
	logic [`PCS_PC_W-1:0] pc;
	logic [`PCS_PC_W-1:0] next_pc;
	logic [`PCS_LOW_W-1:0] latch;
	logic [`PCS_PC_W-1:0] stack_top;
	logic push;
	logic pop;
	logic self_ref;
	logic [`PCS_IND_ADDR_W-1:0] ind_addr;

	// =================================================================
	// return stack
	// call pushes the return address; interrupt pushes the interrupted pc
	assign push = (I_FLOW.op == PCS_OP_CALL) || (I_FLOW.op == PCS_OP_IRQ); // [R8]
	assign pop = (I_FLOW.op == PCS_OP_RET); // [R9]
	pcs_ret_stack #(
		.DEPTH(`PCS_DEPTH),
		.WIDTH(`PCS_PC_W)
	) u_stack (
		.i_clk(I_SYS_CLK),
		.i_rst_n(I_RST_N),
		.i_push(push),
		.i_pop(pop),
		.i_data((I_FLOW.op == PCS_OP_CALL) ? 13'(pc + 1'b1) : pc),
		.o_top(stack_top)
	);

	// =================================================================
	// next counter value, one operation per cycle
	always_comb
	begin
		next_pc = pc;
		unique case (I_FLOW.op)
			PCS_OP_NONE: next_pc = pc;
			PCS_OP_STEP: next_pc = 13'(pc + 1'b1); // [R17]
			PCS_OP_JUMP, PCS_OP_CALL: next_pc = {latch[`PCS_JMP_HI_MSB:`PCS_JMP_HI_LSB],
				I_FLOW.target}; // [R5]
			PCS_OP_RET: next_pc = stack_top; // [R9]
			PCS_OP_IRQ: next_pc = I_FLOW.vector;
			PCS_OP_LOW_WR: next_pc = {latch[`PCS_HIGH_W-1:0], I_FLOW.low_data}; // [R4] [R2]
			default: next_pc = pc;
		endcase
	end

	// counter register; high bits have no direct write path
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_N)
			pc <= `PCS_PC_RST; // [R3]
		else
			pc <= next_pc; // [R1]
	end

	// latch: written only by software, never by stack traffic
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_N)
			latch <= `PCS_LATCH_RST;
		else if (I_LATCH_WR)
			latch <= I_LATCH_DATA; // [R10] [R6]
	end

	assign O_INSTRUCTION_POINTER = pc;
	assign O_COUNTER_LOW_BYTE = pc[`PCS_LOW_W-1:0]; // [R1]
	assign O_UPPER_ADDRESS_LATCH = latch;

	// =================================================================
	// indirect addressing; address combinational so memory sees it same cycle
	assign ind_addr = {I_INDIRECT_BANK_SELECT, I_FILE_POINTER}; // [R16] [R18]
	// pointer to the virtual register in any of the four banks refers to itself
	assign self_ref = (I_FILE_POINTER[6:0] == `PCS_IND_REG_ADDR);
	assign O_MEM_ADDR = ind_addr; // [R13]
	assign O_MEM_RD = I_IND.rd && !self_ref; // [R13]
	assign O_MEM_WR = I_IND.wr && !self_ref; // [R15]
	assign O_MEM_WDATA = I_IND.wdata;
	assign O_IND_RDATA = self_ref ? `PCS_ZERO_BYTE : I_MEM_RDATA; // [R14]

	// =================================================================
	// checks
	property p_reset_clears;
		@(posedge I_SYS_CLK) !I_RST_N |=> (pc == 13'h0000);
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("pc not cleared"); // [R3]
	property p_low_write;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_FLOW.op == PCS_OP_LOW_WR |=>
		pc == {$past(latch[4:0]), $past(I_FLOW.low_data)};
	endproperty
	a_low_write: assert property (p_low_write) else $error("low write load wrong"); // [R4]
	property p_jump;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_FLOW.op == PCS_OP_JUMP |=> pc == {$past(latch[4:3]), $past(I_FLOW.target)};
	endproperty
	a_jump: assert property (p_jump) else $error("jump load wrong"); // [R5]
	property p_step;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_FLOW.op == PCS_OP_STEP |=> pc == 13'($past(pc) + 1'b1);
	endproperty
	a_step: assert property (p_step) else $error("step wrong"); // [R17]
	property p_call_ret;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		(I_FLOW.op == PCS_OP_CALL) ##1 (I_FLOW.op == PCS_OP_RET) |=>
		pc == 13'($past(pc, 2) + 1'b1);
	endproperty
	a_call_ret: assert property (p_call_ret) else $error("return address wrong"); // [R8]
	property p_irq_ret;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		(I_FLOW.op == PCS_OP_IRQ) ##1 (I_FLOW.op == PCS_OP_RET) |=> pc == $past(pc, 2);
	endproperty
	a_irq_ret: assert property (p_irq_ret) else $error("interrupt return wrong"); // [R9]
	property p_latch_kept;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		(push || pop) && !I_LATCH_WR |=> $stable(latch);
	endproperty
	a_latch_kept: assert property (p_latch_kept) else $error("latch changed"); // [R10]
	property p_self_read;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_IND.rd && self_ref |-> O_IND_RDATA == 8'h00 && !O_MEM_RD;
	endproperty
	a_self_read: assert property (p_self_read) else $error("self read not zero"); // [R14]
	property p_self_write;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		self_ref |-> !O_MEM_WR;
	endproperty
	a_self_write: assert property (p_self_write) else $error("self write stored"); // [R15]
	property p_addr;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		O_MEM_ADDR[8] == I_INDIRECT_BANK_SELECT && O_MEM_ADDR[7:0] == I_FILE_POINTER;
	endproperty
	a_addr: assert property (p_addr) else $error("indirect address wrong"); // [R16]
	// every load source of the counter, one property each
	property p_call_load;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_FLOW.op == PCS_OP_CALL |=> pc == {$past(latch[4:3]), $past(I_FLOW.target)};
	endproperty
	a_call_load: assert property (p_call_load) else $error("call load wrong"); // [R5]
	property p_irq_load;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_FLOW.op == PCS_OP_IRQ |=> pc == $past(I_FLOW.vector);
	endproperty
	a_irq_load: assert property (p_irq_load) else $error("vector load wrong"); // [R8]
	property p_hold;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_FLOW.op == PCS_OP_NONE |=> pc == $past(pc);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while idle"); // [R17]
	// the pushed word must be the one that shows on top next cycle
	property p_push_top;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_FLOW.op == PCS_OP_CALL |=> stack_top == 13'($past(pc) + 1'b1);
	endproperty
	a_push_top: assert property (p_push_top) else $error("call pushed wrong word"); // [R8]
	property p_irq_top;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_FLOW.op == PCS_OP_IRQ |=> stack_top == $past(pc);
	endproperty
	a_irq_top: assert property (p_irq_top) else $error("interrupt pushed wrong word"); // [R8]
	property p_pop_load;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_FLOW.op == PCS_OP_RET |=> pc == $past(stack_top);
	endproperty
	a_pop_load: assert property (p_pop_load) else $error("pop load wrong"); // [R9]
	// ordinary pointers must reach memory untouched
	property p_ind_read;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_IND.rd && !self_ref |-> O_MEM_RD && O_IND_RDATA == I_MEM_RDATA;
	endproperty
	a_ind_read: assert property (p_ind_read) else $error("indirect read lost"); // [R13]
	property p_ind_write;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_IND.wr && !self_ref |-> O_MEM_WR && O_MEM_WDATA == I_IND.wdata;
	endproperty
	a_ind_write: assert property (p_ind_write) else $error("indirect write lost"); // [R13]
	property p_cov_call;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N) I_FLOW.op == PCS_OP_CALL;
	endproperty
	c_cov_call: cover property (p_cov_call);
	property p_cov_low;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N) I_FLOW.op == PCS_OP_LOW_WR;
	endproperty
	c_cov_low: cover property (p_cov_low);
	property p_cov_self;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N) I_IND.rd && self_ref;
	endproperty
	c_cov_self: cover property (p_cov_self);
	property p_cov_call_ret;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_FLOW.op == PCS_OP_CALL ##1 I_FLOW.op == PCS_OP_RET;
	endproperty
	c_cov_call_ret: cover property (p_cov_call_ret);
	property p_cov_irq;
		@(posedge I_SYS_CLK) disable iff (!I_RST_N) I_FLOW.op == PCS_OP_IRQ;
	endproperty
	c_cov_irq: cover property (p_cov_irq);
endmodule

//--- core/pcs_pkg.sv
// Purpose: types for the program counter block
// Assumes: pcs_defs.svh constants
// Notes: operation code carried from the execution unit
`include "pcs_defs.svh"
package pcs_pkg;
	// =================================================================
	// flow operations, one per executed instruction
	typedef enum logic [2:0]
	{
		PCS_OP_NONE = 3'h0,
		PCS_OP_STEP = 3'h1,
		PCS_OP_JUMP = 3'h2,
		PCS_OP_CALL = 3'h3,
		PCS_OP_RET = 3'h4,
		PCS_OP_IRQ = 3'h5,
		PCS_OP_LOW_WR = 3'h6
	} pcs_op_t;
	// request from the execution unit
	typedef struct packed
	{
		pcs_op_t op;
		logic [`PCS_JMP_W-1:0] target;
		logic [`PCS_PC_W-1:0] vector;
		logic [`PCS_LOW_W-1:0] low_data;
	} pcs_flow_req_t;
	// indirect access request
	typedef struct packed
	{
		logic rd;
		logic wr;
		logic [`PCS_LOW_W-1:0] wdata;
	} pcs_ind_req_t;
endpackage

//--- core/pcs_ret_stack.sv
// Purpose: circular return-address stack
// Assumes: push and pop never in the same cycle
// Notes: no overflow or underflow indication by design
`timescale 1ns/1ps
`include "pcs_defs.svh"
module pcs_ret_stack #(
	parameter int DEPTH = `PCS_DEPTH,
	parameter int WIDTH = `PCS_PC_W
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_push,
	input wire logic i_pop,
	input wire logic [WIDTH-1:0] i_data,
	output logic [WIDTH-1:0] o_top
);
	localparam int PW = $clog2(DEPTH);
	// refuse depths that a wrapping binary pointer cannot serve
	if (DEPTH < 2 || (1 << PW) != DEPTH)
	begin : g_bad_depth
		$error("stack depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] ptr;
	// =================================================================
	// pointer wraps silently both ways; software cannot see it
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			ptr <= '0;
		else if (i_push)
			ptr <= PW'(ptr + 1'b1); // [R11] [R12]
		else if (i_pop)
			ptr <= PW'(ptr - 1'b1); // [R12]
	end
	// storage needs no reset; contents after reset are don't-care
	always_ff @(posedge i_clk)
	begin
		if (i_push)
			mem[ptr] <= i_data; // [R7] [R11]
	end
	assign o_top = mem[PW'(ptr - 1'b1)];
endmodule

//--- dv/pcs_mem_model.sv
// Purpose: data memory model on the far side of the indirect port
// Assumes: write on the rising edge, read combinational
// Notes: idle read data toggles so a stale value never passes for a read
`timescale 1ns/1ps
module pcs_mem_model (
	input wire logic i_clk,
	input wire logic [8:0] i_addr,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:511];
	logic [7:0] last = 8'h00;
	// =================================================================
	// storage and idle pattern
	always_ff @(posedge i_clk)
	begin
		if (i_wr)
			mem[i_addr] <= i_wdata;
		last <= o_rdata;
	end
	// unselected reads show the inverse of the last value
	always_comb
	begin
		o_rdata = i_rd ? mem[i_addr] : ~last;
	end
endmodule

//--- dv/tb.sv
// Purpose: self-checking bench for the program counter block
// Assumes: the bench acts as the execution unit
// Notes: memory model answers the indirect port
`timescale 1ns/1ps
`include "pcs_defs.svh"
module tb;
	import pcs_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	pcs_flow_req_t flow = '0;
	pcs_ind_req_t ind = '0;
	logic latch_wr = 1'b0;
	logic [7:0] latch_data = 8'h00;
	logic [7:0] fptr = 8'h00;
	logic bank = 1'b0;
	logic [7:0] mem_rdata, counter_low_byte, latch, ird, mwdata;
	logic [12:0] pc, saved;
	logic [8:0] maddr;
	logic mrd, mwr;
	int fails = 0;
	int checks = 0;
	pcs_flow dut (.I_SYS_CLK(sys_clk), .I_RST_N(rst_n), .I_FLOW(flow),
		.I_LATCH_WR(latch_wr), .I_LATCH_DATA(latch_data), .I_FILE_POINTER(fptr),
		.I_INDIRECT_BANK_SELECT(bank), .I_IND(ind), .I_MEM_RDATA(mem_rdata),
		.O_INSTRUCTION_POINTER(pc), .O_COUNTER_LOW_BYTE(counter_low_byte),
		.O_UPPER_ADDRESS_LATCH(latch), .O_MEM_ADDR(maddr), .O_MEM_RD(mrd),
		.O_MEM_WR(mwr), .O_MEM_WDATA(mwdata), .O_IND_RDATA(ird));
	pcs_mem_model mem (.i_clk(sys_clk), .i_addr(maddr), .i_rd(mrd), .i_wr(mwr),
		.i_wdata(mwdata), .o_rdata(mem_rdata));
	// =================================================================
	// clock and helpers
	initial
	begin
		forever #10 sys_clk = ~sys_clk;
	end
	task chk(input logic [12:0] got, input logic [12:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one operation, taken at the second edge, result settled after it
	task op(input pcs_op_t o, input logic [10:0] t, input logic [12:0] v, input logic [7:0] d);
		@(posedge sys_clk);
		flow <= '{o, t, v, d};
		@(posedge sys_clk);
		flow.op <= PCS_OP_NONE;
		#1;
	endtask
	// two operations on consecutive edges, no idle cycle between them
	task pair(input pcs_op_t a, input logic [10:0] t, input logic [12:0] v, input pcs_op_t b);
		@(posedge sys_clk);
		flow <= '{a, t, v, 8'h00};
		@(posedge sys_clk);
		flow.op <= b;
		@(posedge sys_clk);
		flow.op <= PCS_OP_NONE;
		#1;
	endtask
	task set_latch(input logic [7:0] d);
		@(posedge sys_clk);
		latch_wr <= 1'b1;
		latch_data <= d;
		@(posedge sys_clk);
		latch_wr <= 1'b0;
		#1;
	endtask
	// indirect port is combinational, so look just after the change
	task indir(input logic [7:0] p, input logic b, input logic r, input logic w,
		input logic [7:0] d);
		@(posedge sys_clk);
		fptr <= p;
		bank <= b;
		ind <= '{r, w, d};
		#1;
	endtask
	task final_report;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// =================================================================
	// tests
	initial
	begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		chk(pc, 13'h0000);
		op(PCS_OP_STEP, 11'h0, 13'h0, 8'h0);
		chk(pc, 13'h0001);
		set_latch(8'h1f);
		op(PCS_OP_LOW_WR, 11'h0, 13'h0, 8'h34);
		chk(pc, 13'h1f34);
		chk(13'(counter_low_byte), 13'h0034);
		op(PCS_OP_JUMP, 11'h123, 13'h0, 8'h0);
		chk(pc, 13'h1923);
		// nine calls, one more than the stack holds
		set_latch(8'h0f);
		for (int i = 0; i < 9; i++)
		begin
			op(PCS_OP_JUMP, 11'(i * 16), 13'h0, 8'h0);
			op(PCS_OP_CALL, 11'h7ff, 13'h0, 8'h0);
			chk(pc, 13'h0fff);
		end
		for (int k = 0; k < 9; k++)
		begin
			op(PCS_OP_RET, 11'h0, 13'h0, 8'h0);
			chk(pc, 13'(13'h0801 + 16 * ((k == 8) ? 8 : 8 - k)));
			chk(13'(latch), 13'h000f);
		end
		saved = pc;
		op(PCS_OP_IRQ, 11'h0, 13'h0004, 8'h0);
		chk(pc, 13'h0004);
		op(PCS_OP_RET, 11'h0, 13'h0, 8'h0);
		chk(pc, saved);
		pair(PCS_OP_CALL, 11'h0aa, 13'h0, PCS_OP_RET);
		chk(pc, 13'(saved + 13'h1));
		pair(PCS_OP_IRQ, 11'h0, 13'h0004, PCS_OP_RET);
		chk(pc, 13'(saved + 13'h1));
		set_latch(8'h1f);
		op(PCS_OP_LOW_WR, 11'h0, 13'h0, 8'hff);
		op(PCS_OP_STEP, 11'h0, 13'h0, 8'h0);
		chk(pc, 13'h0000);
		set_latch(8'h02); // table crossed 0xff, latch bumped first
		op(PCS_OP_LOW_WR, 11'h0, 13'h0, 8'h10);
		chk(pc, 13'h0210);
		indir(8'h20, 1'b1, 1'b0, 1'b1, 8'ha5);
		chk(13'(maddr), 13'h0120);
		chk(13'(mwr), 13'h0001);
		chk(13'(mwdata), 13'h00a5);
		indir(8'h20, 1'b1, 1'b1, 1'b0, 8'h00);
		chk(13'(ird), 13'h00a5);
		chk(13'(mrd), 13'h0001);
		indir(8'h80, 1'b0, 1'b1, 1'b0, 8'h00);
		chk(13'(ird), 13'h0000);
		chk(13'(mrd), 13'h0000);
		indir(8'h00, 1'b1, 1'b0, 1'b1, 8'h3c);
		chk(13'(mwr), 13'h0000);
		indir(8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		// second reset in mid-run
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		chk(pc, 13'h0000);
		final_report();
	end
	// watchdog well beyond the hundred or so cycles the tests need
	initial
	begin
		#20000;
		fails++;
		final_report();
	end
endmodule
